// [srfc_flow_ctrl.sv]
// Top of the serial RTS/CTS flow-control block.
//
// Overview of operation
// - Hardware mode: RTS high unless buffer nearly full.
// - Hardware mode: RTS low above two-thirds fill.
// - RTS returns high once fill drops below.
// - Hardware mode: transmit only while CTS high.
// - Modem mode: raise RTS while data queued.
// - Modem mode: start sending only after CTS.
// - Modem mode: keep sending while CTS, data.
// - Modem mode: pause on CTS low, resume later.
// - Modem mode: drop RTS when queue drained.
// - Hardware and modem modes: hold queued characters while CTS is low.
// - Modem mode, no CTS: keep RTS until command timeout.
`default_nettype none
module srfc_flow_ctrl #(
    parameter int RX_DEPTH = 1024,
    parameter int CW = $clog2(RX_DEPTH + 1)
) (
    // Clock, reset and enable.
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // Configuration.
    input wire srfc_pkg::srfc_mode_t mode_i,
    // Receive buffer fill level.
    input wire logic [CW-1:0] rx_count_i,
    // Transmit queue status and command timeout.
    input wire logic tx_pending_i,
    input wire logic cmd_timeout_i,
    // Serial lines.
    input wire logic cts_i,
    output logic rts_o,
    // Permission for the transmitter to shift the next character.
    output logic tx_en_o,
    // Modem attempt abandoned on timeout, one-cycle pulse.
    output logic tx_abort_o
);
    import srfc_pkg::*;

    // ==========================================================
    // Receive throttle.
    logic throttle;

    srfc_rx_throttle #(
        .DEPTH(RX_DEPTH),
        .CW(CW)
    ) srfc_rx_throttle_inst (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .rx_count_i(rx_count_i),
        .throttle_o(throttle)
    );

    // ==========================================================
    // Modem handshake sequencer and line outputs.
    srfc_state_t st_q;
    srfc_state_t st_d;
    srfc_line_t line_q;
    srfc_line_t line_d;
    logic abort_q;
    logic abort_d;

    always_comb begin
        st_d = st_q;
        abort_d = 1'b0;
        line_d.rts = 1'b0;
        line_d.tx_en = 1'b0;
        case (mode_i)
            SRFC_MODE_HW: begin
                st_d = SRFC_ST_IDLE;
                line_d.rts = ~throttle;
                line_d.tx_en = cts_i & tx_pending_i;
            end
            SRFC_MODE_MODEM: begin
                case (st_q)
                    SRFC_ST_IDLE: begin
                        if (tx_pending_i) begin
                            st_d = SRFC_ST_WAIT;
                        end
                    end
                    SRFC_ST_WAIT: begin
                        if (!tx_pending_i) begin
                            st_d = SRFC_ST_IDLE;
                        end else if (cmd_timeout_i) begin
                            st_d = SRFC_ST_IDLE;
                            abort_d = 1'b1;
                        end else if (cts_i) begin
                            st_d = SRFC_ST_SEND;
                        end
                    end
                    SRFC_ST_SEND: begin
                        if (!tx_pending_i) begin
                            st_d = SRFC_ST_IDLE;
                        end else if (!cts_i) begin
                            st_d = SRFC_ST_WAIT;
                        end
                    end
                    default: begin
                        st_d = SRFC_ST_IDLE;
                    end
                endcase
                line_d.rts = (st_d != SRFC_ST_IDLE);
                line_d.tx_en = (st_d == SRFC_ST_SEND) && cts_i;
            end
            default: begin
                st_d = SRFC_ST_IDLE;
                line_d.rts = 1'b1;
                line_d.tx_en = tx_pending_i;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= SRFC_ST_IDLE;
            line_q.rts <= SRFC_RTS_RST;
            line_q.tx_en <= SRFC_TX_EN_RST;
            abort_q <= 1'b0;
        end else if (clk_en_i) begin
            st_q <= st_d;
            line_q <= line_d;
            abort_q <= abort_d;
        end
    end

    assign rts_o = line_q.rts;
    assign tx_en_o = line_q.tx_en;
    assign tx_abort_o = abort_q;
endmodule
`default_nettype wire

// [srfc_flow_ctrl_properties.sv]
// Port assertions for the RTS/CTS flow-control block.
`default_nettype none
module srfc_flow_ctrl_properties
    import srfc_pkg::*;
#(
    parameter int RX_DEPTH = 1024,
    parameter int CW = $clog2(RX_DEPTH + 1)
) (
    // Inputs and outputs of the block.
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire srfc_pkg::srfc_mode_t mode_i,
    input wire logic [CW-1:0] rx_count_i,
    input wire logic tx_pending_i,
    input wire logic cmd_timeout_i,
    input wire logic cts_i,
    input wire logic rts_o,
    input wire logic tx_en_o,
    input wire logic tx_abort_o
);
    localparam int THR = RX_DEPTH * SRFC_THR_NUM / SRFC_THR_DEN;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i || !clk_en_i);
    logic hw;
    logic mdm;
    assign hw = mode_i == SRFC_MODE_HW;
    assign mdm = mode_i == SRFC_MODE_MODEM;
    sequence over_s; hw && rx_count_i > THR; endsequence
    sequence under_s; hw && rx_count_i < THR; endsequence
    a_hw_throttle: assert property (over_s [*2] |=> !rts_o) else $error("rts high over threshold");
    a_hw_release: assert property (under_s [*2] |=> rts_o) else $error("rts low under threshold");
    a_hw_cts_gate: assert property (hw && !cts_i |=> !tx_en_o) else $error("sent with cts low");
    a_hw_cts_send: assert property (hw && cts_i && tx_pending_i |=> tx_en_o) else $error("no send");
    a_modem_rts: assert property (
        mdm && tx_pending_i && !cmd_timeout_i && !tx_abort_o |=> rts_o) else $error("rts not raised");
    a_modem_gate: assert property (mdm && !cts_i |=> !tx_en_o) else $error("sent without cts");
    a_modem_send: assert property (
        mdm && $past(mdm) && cts_i && rts_o && tx_pending_i && !cmd_timeout_i |=> tx_en_o)
        else $error("modem send stalled");
    a_modem_drop: assert property (
        mdm && !tx_pending_i && !cmd_timeout_i |=> !rts_o && !tx_en_o) else $error("rts kept after drain");
    a_abort_pulse: assert property (
        tx_abort_o |-> $past(cmd_timeout_i) ##1 !tx_abort_o) else $error("bad abort pulse");
    a_none_free: assert property (
        mode_i == SRFC_MODE_NONE |=> rts_o && tx_en_o == $past(tx_pending_i)) else $error("mode none wrong");
endmodule
bind srfc_flow_ctrl srfc_flow_ctrl_properties #(.RX_DEPTH(RX_DEPTH), .CW(CW)) chk_inst (.*);
`default_nettype wire

// [srfc_modem_model.sv]
// Modem model that grants CTS three cycles after RTS unless held off.
`default_nettype none
module srfc_modem_model (
    input wire logic clk_i,
    input wire logic rts_i,
    input wire logic hold_i,
    output logic cts_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] dly_q = 2'h0;
    initial cts_o = 1'b0;
    always @(posedge clk_i) begin
        dly_q <= rts_i ? {dly_q[0], 1'b1} : 2'h0;
        cts_o <= rts_i && dly_q[1] && !hold_i;
    end
endmodule
`default_nettype wire

// [srfc_pkg.sv]
// Package of types and constants for the serial RTS/CTS flow-control block.
`default_nettype none
package srfc_pkg;
    // Handshake scheme selection codes.
    typedef enum logic [1:0] {
        SRFC_MODE_NONE  = 2'b00,
        SRFC_MODE_HW    = 2'b01,
        SRFC_MODE_MODEM = 2'b10
    } srfc_mode_t;

    // Modem handshake states.
    typedef enum logic [1:0] {
        SRFC_ST_IDLE = 2'b00,
        SRFC_ST_WAIT = 2'b01,
        SRFC_ST_SEND = 2'b10
    } srfc_state_t;

    // Throttle threshold as a fraction of receive buffer capacity.
    localparam int SRFC_THR_NUM = 2;
    localparam int SRFC_THR_DEN = 3;

    // Reset values of the line outputs.
    localparam logic SRFC_RTS_RST = 1'b0;
    localparam logic SRFC_TX_EN_RST = 1'b0;

    // Line outputs carried together.
    typedef struct packed {
        logic rts;
        logic tx_en;
    } srfc_line_t;
endpackage
`default_nettype wire

// [srfc_rx_throttle.sv]
// Receive-side RTS throttle comparator that holds its state at the threshold.
`default_nettype none
module srfc_rx_throttle #(
    parameter int DEPTH = 1024,
    parameter int CW = $clog2(DEPTH + 1)
) (
    // Clock, reset and enable.
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // Buffer fill level.
    input wire logic [CW-1:0] rx_count_i,
    // Throttle request.
    output logic throttle_o
);
    import srfc_pkg::*;

    localparam logic [CW-1:0] THRESH = CW'((DEPTH * SRFC_THR_NUM) / SRFC_THR_DEN);

    logic throttle_d;
    logic throttle_q;

    // Above threshold throttles; below releases; at threshold holds.
    always_comb begin
        throttle_d = throttle_q;
        if (rx_count_i > THRESH) begin
            throttle_d = 1'b1;
        end else if (rx_count_i < THRESH) begin
            throttle_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            throttle_q <= 1'b0;
        end else if (clk_en_i) begin
            throttle_q <= throttle_d;
        end
    end

    assign throttle_o = throttle_q;
endmodule
`default_nettype wire

// [tb_srfc_flow_ctrl.sv]
// Self-checking bench for the RTS/CTS flow-control block.
`default_nettype none
module tb_srfc_flow_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import srfc_pkg::*;
    logic clk = 0, rstn = 0, pend = 0, tmo = 0, hold = 1, en = 1;
    logic cts, rts, txen, abrt;
    logic [3:0] cnt = 4'h0;
    srfc_mode_t mode = SRFC_MODE_NONE;
    int fails = 0, check_count = 0, cyc = 0;
    always #2.5 clk = ~clk;
    srfc_flow_ctrl #(.RX_DEPTH(12)) srfc_flow_ctrl_inst (.core_clk_i(clk), .resetn_i(rstn), .clk_en_i(en),
        .mode_i(mode), .rx_count_i(cnt), .tx_pending_i(pend), .cmd_timeout_i(tmo), .cts_i(cts),
        .rts_o(rts), .tx_en_o(txen), .tx_abort_o(abrt));
    srfc_modem_model srfc_modem_model_inst (.clk_i(clk), .rts_i(rts), .hold_i(hold), .cts_o(cts));
    task chk(logic a, logic e);
        check_count++;
        if (a !== e) begin
            fails++;
            $display("mismatch at %0t: output differs", $time);
        end
    endtask
    task step(int n);
        repeat (n) @(negedge clk);
    endtask
    task final_report;
        if (fails == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task hw_test;
        mode = SRFC_MODE_HW; pend = 1; hold = 0; cnt = 4'h9; step(3);
        chk(rts, 0);
        cnt = 4'h8; step(3);
        chk(rts, 0);
        cnt = 4'h7; step(3);
        chk(rts, 1);
        hold = 1; step(3);
        chk(txen, 0);
        hold = 0; step(4);
        chk(txen, 1);
    endtask
    task modem_test;
        mode = SRFC_MODE_MODEM; pend = 0; step(2);
        chk(rts, 0);
        hold = 1; pend = 1; step(2);
        chk(rts, 1);
        chk(txen, 0);
        hold = 0; step(5);
        chk(txen, 1);
        hold = 1; step(2);
        chk(txen, 0);
        hold = 0; step(5);
        chk(txen, 1);
        pend = 0; step(2);
        chk(rts, 0);
        hold = 1; pend = 1; step(4);
        chk(rts, 1);
        tmo = 1; step(1);
        chk(abrt, 1);
        chk(rts, 0);
        tmo = 0; pend = 0; step(1);
        chk(abrt, 0);
    endtask
    task none_test;
        mode = srfc_mode_t'(2'h3); step(2);
        chk(rts, 1);
        pend = 1; mode = SRFC_MODE_NONE; step(2);
        chk(txen, 1);
        en = 0; pend = 0; step(3);
        chk(txen, 1);
        en = 1; step(2);
        chk(txen, 0);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        step(2);
        rstn = 1;
        hw_test();
        modem_test();
        none_test();
        final_report();
    end
endmodule
`default_nettype wire
